// ==== src/sysd_pkg.sv ====
/*
  Shared constants and types for the system descriptor decoder: descriptor
  type codes, field positions in the two descriptor words, decode classes,
  fault vectors and the APB register map.
  Assumes it is compiled before every other file of the block.
*/
package sysd_pkg;

  // Descriptor type codes
  localparam logic [3:0] TY_INV0      = 4'h0;
  localparam logic [3:0] TY_TSS16_AV  = 4'h1;
  localparam logic [3:0] TY_LDT       = 4'h2;
  localparam logic [3:0] TY_TSS16_BSY = 4'h3;
  localparam logic [3:0] TY_CALL16    = 4'h4;
  localparam logic [3:0] TY_TASKG     = 4'h5;
  localparam logic [3:0] TY_INT16     = 4'h6;
  localparam logic [3:0] TY_TRAP16    = 4'h7;
  localparam logic [3:0] TY_INV8      = 4'h8;
  localparam logic [3:0] TY_TSS32_AV  = 4'h9;
  localparam logic [3:0] TY_RSV_A     = 4'hA;
  localparam logic [3:0] TY_TSS32_BSY = 4'hB;
  localparam logic [3:0] TY_CALL32    = 4'hC;
  localparam logic [3:0] TY_RSV_D     = 4'hD;
  localparam logic [3:0] TY_INT32     = 4'hE;
  localparam logic [3:0] TY_TRAP32    = 4'hF;

  // Field positions in the high descriptor word
  localparam int HI_BASE_MID_LSB = 0;
  localparam int HI_WC_LSB       = 0;
  localparam int HI_TYPE_LSB     = 8;
  localparam int HI_NATIVE_BIT   = 11;
  localparam int HI_S_BIT        = 12;
  localparam int HI_DPL_LSB      = 13;
  localparam int HI_P_BIT        = 15;
  localparam int HI_UPPER_LSB    = 16;
  localparam int HI_LIM_HI_LSB   = 16;
  localparam int HI_G_BIT        = 23;
  localparam int HI_BASE_HI_LSB  = 24;
  // Field positions in the low descriptor word
  localparam int LO_LIMIT_LSB    = 0;
  localparam int LO_BASE_LSB     = 16;

  // Decode classes, one-hot
  typedef enum logic [6:0] {
    CL_INVALID = 7'h01,
    CL_LDT     = 7'h02,
    CL_TSS     = 7'h04,
    CL_CALL    = 7'h08,
    CL_TASK    = 7'h10,
    CL_INTR    = 7'h20,
    CL_TRAP    = 7'h40
  } sysd_class_t;

  // Fault vectors
  localparam logic [7:0] VEC_NONE        = 8'h00;
  localparam logic [7:0] VEC_NOT_PRESENT = 8'h0B;
  localparam logic [7:0] VEC_GEN_PROT    = 8'h0D;

  // APB register map
  localparam logic [7:0]  OFF_CTRL     = 8'h00;
  localparam logic [7:0]  OFF_TASK     = 8'h04;
  localparam logic [7:0]  OFF_STATUS   = 8'h08;
  localparam logic [7:0]  OFF_FAULTS   = 8'h0C;
  localparam logic [7:0]  OFF_DECODES  = 8'h10;
  localparam int          CTRL_EN_BIT  = 0;
  localparam int          CTRL_CLR_BIT = 1;
  localparam logic [31:0] CTRL_RST     = 32'h0000_0001;
  localparam logic [15:0] TASK_RST     = 16'h0000;

endpackage

// ==== src/sysd_dec_if.sv ====
/*
  Carrier between the decoder top and its two helpers: the raw descriptor
  words go out, the extracted fields and the type class come back.
  Assumes sysd_pkg is compiled first.
*/
`timescale 1ns/1ns
interface sysd_dec_if;
  logic [31:0]          lo;
  logic [31:0]          hi;
  logic [31:0]          base;
  logic [19:0]          limit;
  logic [15:0]          sel;
  logic [31:0]          offset;
  logic [4:0]           wc;
  logic                 upper_zero;
  sysd_pkg::sysd_class_t cls;
  logic                 tss_busy;
  logic                 native;
  logic                 reserved;

  modport top (output lo, hi,
               input  base, limit, sel, offset, wc, upper_zero, cls, tss_busy, native, reserved);
  modport ext (input  lo, hi,
               output base, limit, sel, offset, wc, upper_zero);
  modport typ (input  hi,
               output cls, tss_busy, native, reserved);
endinterface

// ==== src/sysd_field_ext.sv ====
/*
  Pulls base, limit, selector, offset and word count out of the two
  descriptor words, in the short or the full layout.
  Assumes the words are stable for the whole cycle; purely combinational.
*/
`timescale 1ns/1ns
module sysd_field_ext (
  // Descriptor words in, fields out
  sysd_dec_if.ext d
);
  wire native = d.hi[sysd_pkg::HI_NATIVE_BIT];

  // Short layout when the upper word is clear
  assign d.upper_zero = (d.hi[sysd_pkg::HI_UPPER_LSB +: 16] == 16'h0000);
  assign d.base  = {d.upper_zero ? 8'h00 : d.hi[sysd_pkg::HI_BASE_HI_LSB +: 8],
                    d.hi[sysd_pkg::HI_BASE_MID_LSB +: 8], d.lo[sysd_pkg::LO_BASE_LSB +: 16]};
  assign d.limit = {d.upper_zero ? 4'h0 : d.hi[sysd_pkg::HI_LIM_HI_LSB +: 4],
                    d.lo[sysd_pkg::LO_LIMIT_LSB +: 16]};

  // Gate pointer: offset is 16 bits for short gates
  assign d.sel    = d.lo[sysd_pkg::LO_BASE_LSB +: 16];
  assign d.offset = {native ? d.hi[sysd_pkg::HI_UPPER_LSB +: 16] : 16'h0000,
                     d.lo[sysd_pkg::LO_LIMIT_LSB +: 16]};
  assign d.wc     = d.hi[sysd_pkg::HI_WC_LSB +: 5];
endmodule

// ==== src/sysd_type_class.sv ====
/*
  Sorts the 4-bit system type into a one-hot class and the busy, native
  and reserved flags.
  Assumes the high descriptor word is stable; purely combinational.
*/
`timescale 1ns/1ns
module sysd_type_class (
  // High word in, class out
  sysd_dec_if.typ d
);
  wire [3:0] ty = d.hi[sysd_pkg::HI_TYPE_LSB +: 4];

  // Type to class mapping
  function automatic sysd_pkg::sysd_class_t class_of(input logic [3:0] t);
    case (t)
      sysd_pkg::TY_LDT:                                          class_of = sysd_pkg::CL_LDT;
      sysd_pkg::TY_TSS16_AV, sysd_pkg::TY_TSS16_BSY,
      sysd_pkg::TY_TSS32_AV, sysd_pkg::TY_TSS32_BSY:             class_of = sysd_pkg::CL_TSS;
      sysd_pkg::TY_CALL16, sysd_pkg::TY_CALL32:                  class_of = sysd_pkg::CL_CALL;
      sysd_pkg::TY_TASKG:                                        class_of = sysd_pkg::CL_TASK;
      sysd_pkg::TY_INT16, sysd_pkg::TY_INT32:                    class_of = sysd_pkg::CL_INTR;
      sysd_pkg::TY_TRAP16, sysd_pkg::TY_TRAP32:                  class_of = sysd_pkg::CL_TRAP;
      default:                                                   class_of = sysd_pkg::CL_INVALID;
    endcase
  endfunction

  // Class and flags
  assign d.cls      = class_of(ty);
  assign d.tss_busy = (ty == sysd_pkg::TY_TSS16_BSY) | (ty == sysd_pkg::TY_TSS32_BSY);
  assign d.native   = ty[3];
  assign d.reserved = (ty == sysd_pkg::TY_INV0) | (ty == sysd_pkg::TY_INV8) |
                      (ty == sysd_pkg::TY_RSV_A) | (ty == sysd_pkg::TY_RSV_D);
endmodule

// ==== src/sysd_decoder.sv ====
/*
  System descriptor decoder top: takes an eight-byte system descriptor,
  classifies it, extracts its fields, checks it and presents the result
  one clock later, with an APB register window and the current task
  pointer register.
  Assumes descriptor words and qualifiers come from logic on i_ref_clk and
  an APB master on the same clock.
*/
`timescale 1ns/1ns
module sysd_decoder #(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input  wire logic                  i_ref_clk,
  input  wire logic                  i_rst,
  // Descriptor request
  input  wire logic                  i_desc_valid,
  input  wire logic [31:0]           i_desc_lo,
  input  wire logic [31:0]           i_desc_hi,
  input  wire logic                  i_from_gdt,
  input  wire logic                  i_priv_change,
  input  wire logic                  i_dest_known,
  input  wire logic                  i_dest_is_code,
  input  wire logic                  i_dest_is_tss,
  // Task pointer load from task switch
  input  wire logic                  i_task_load,
  input  wire logic [15:0]           i_task_sel,
  // APB slave
  input  wire logic                  i_psel,
  input  wire logic                  i_penable,
  input  wire logic                  i_pwrite,
  input  wire logic [7:0]            i_paddr,
  input  wire logic [31:0]           i_pwdata,
  output logic [31:0]                o_prdata,
  output logic                       o_pready,
  output logic                       o_pslverr,
  // Decode result
  output logic                       o_valid,
  output sysd_pkg::sysd_class_t      o_class,
  output logic [7:0]                 o_access,
  output logic                       o_present,
  output logic [1:0]                 o_dpl,
  output logic                       o_legacy,
  output logic                       o_tss_busy,
  output logic [31:0]                o_base,
  output logic [19:0]                o_limit,
  output logic                       o_gran,
  output logic [15:0]                o_sel,
  output logic [31:0]                o_offset,
  output logic [4:0]                 o_word_count,
  output logic [4:0]                 o_copy_count,
  output logic                       o_copy_wide,
  output logic                       o_invalid,
  output logic                       o_fault,
  output logic [7:0]                 o_fault_vec,
  // Current task selector
  output logic [15:0]                o_task_ptr
);

  // Helpers on the shared carrier
  sysd_dec_if dif ();
  assign dif.lo = i_desc_lo;
  assign dif.hi = i_desc_hi;

  sysd_field_ext u_ext (
    .d (dif.ext)
  );

  sysd_type_class u_typ (
    .d (dif.typ)
  );

  // Control register and counters
  logic [31:0]      ctrl;
  logic [CNT_W-1:0] decodes;
  logic [CNT_W-1:0] faults;

  // Raw access byte fields
  wire        s_bit    = i_desc_hi[sysd_pkg::HI_S_BIT];
  wire        present  = i_desc_hi[sysd_pkg::HI_P_BIT];
  wire [1:0]  descriptor_privilege_level      = i_desc_hi[sysd_pkg::HI_DPL_LSB +: 2];
  wire [7:0]  access   = i_desc_hi[sysd_pkg::HI_TYPE_LSB +: 8];
  wire        take     = i_desc_valid & ctrl[sysd_pkg::CTRL_EN_BIT];

  // Class qualifiers
  wire is_ldt   = (dif.cls == sysd_pkg::CL_LDT) & ~s_bit;
  wire is_tss   = (dif.cls == sysd_pkg::CL_TSS) & ~s_bit;
  wire is_call  = (dif.cls == sysd_pkg::CL_CALL) & ~s_bit;
  wire is_task  = (dif.cls == sysd_pkg::CL_TASK) & ~s_bit;
  wire is_hand  = ((dif.cls == sysd_pkg::CL_INTR) | (dif.cls == sysd_pkg::CL_TRAP)) & ~s_bit;
  wire is_gate  = is_call | is_task | is_hand;
  wire is_seg   = is_ldt | is_tss;

  // Checks
  wire bad_s    = s_bit;
  wire bad_type = dif.reserved & ~s_bit;
  wire ldt_bad  = is_ldt & ~i_from_gdt;
  wire gate_np  = is_gate & ~present;
  wire dest_bad = is_gate & i_dest_known &
                  (is_task ? ~i_dest_is_tss : ~i_dest_is_code);

  // Fault vector: S bit, type and local table faults before not-present, destination kind after
  wire [7:0] next_fault_vec = (bad_s | bad_type | ldt_bad) ? sysd_pkg::VEC_GEN_PROT :
                              gate_np                      ? sysd_pkg::VEC_NOT_PRESENT :
                              dest_bad                     ? sysd_pkg::VEC_GEN_PROT :
                                                             sysd_pkg::VEC_NONE;
  wire       next_fault     = (next_fault_vec != sysd_pkg::VEC_NONE);

  // Result selection
  wire sysd_pkg::sysd_class_t next_class = s_bit ? sysd_pkg::CL_INVALID : dif.cls;
  wire [1:0]  next_dpl     = is_ldt ? 2'b00 : descriptor_privilege_level;
  wire        next_legacy  = (is_tss | is_gate) ? ~dif.native : dif.upper_zero;
  wire [31:0] next_base    = is_seg ? dif.base : 32'h0000_0000;
  wire [19:0] next_limit   = is_seg ? dif.limit : 20'h0_0000;
  wire        next_gran    = is_seg & ~dif.upper_zero & i_desc_hi[sysd_pkg::HI_G_BIT];
  wire [15:0] next_sel     = is_gate ? dif.sel : 16'h0000;
  wire [31:0] next_offset  = (is_call | is_hand) ? dif.offset : 32'h0000_0000;
  wire [4:0]  next_wc      = is_call ? dif.wc : 5'h00;
  wire [4:0]  next_copy    = (is_call & i_priv_change) ? dif.wc : 5'h00;
  wire        next_wide    = is_call & dif.native;
  wire        next_busy    = is_tss & dif.tss_busy;

  // Decode result registers, loaded one cycle after the request
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_valid      <= 1'b0;
      o_class      <= sysd_pkg::CL_INVALID;
      o_access     <= 8'h00;
      o_present    <= 1'b0;
      o_dpl        <= 2'b00;
      o_legacy     <= 1'b0;
      o_tss_busy   <= 1'b0;
      o_base       <= 32'h0000_0000;
      o_limit      <= 20'h0_0000;
      o_gran       <= 1'b0;
    end else begin
      o_valid      <= take;
      if (take) begin
        o_class    <= next_class;
        o_access   <= access;
        o_present  <= present;
        o_dpl      <= next_dpl;
        o_legacy   <= next_legacy;
        o_tss_busy <= next_busy;
        o_base     <= next_base;
        o_limit    <= next_limit;
        o_gran     <= next_gran;
      end
    end
  end

  // Gate pointer, counts and fault results
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_sel        <= 16'h0000;
      o_offset     <= 32'h0000_0000;
      o_word_count <= 5'h00;
      o_copy_count <= 5'h00;
      o_copy_wide  <= 1'b0;
      o_invalid    <= 1'b0;
      o_fault      <= 1'b0;
      o_fault_vec  <= sysd_pkg::VEC_NONE;
    end else if (take) begin
      o_sel        <= next_sel;
      o_offset     <= next_offset;
      o_word_count <= next_wc;
      o_copy_count <= next_copy;
      o_copy_wide  <= next_wide;
      o_invalid    <= bad_type;
      o_fault      <= next_fault;
      o_fault_vec  <= next_fault_vec;
    end
  end

  // APB decode
  wire apb_acc   = i_psel & i_penable;
  wire apb_done  = apb_acc & o_pready;
  wire hit_ctrl  = (i_paddr == sysd_pkg::OFF_CTRL);
  wire hit_task  = (i_paddr == sysd_pkg::OFF_TASK);
  wire hit_stat  = (i_paddr == sysd_pkg::OFF_STATUS);
  wire hit_flt   = (i_paddr == sysd_pkg::OFF_FAULTS);
  wire hit_dec   = (i_paddr == sysd_pkg::OFF_DECODES);
  wire hit_any   = hit_ctrl | hit_task | hit_stat | hit_flt | hit_dec;
  wire wr_ctrl   = apb_done & i_pwrite & hit_ctrl;
  wire wr_task   = apb_done & i_pwrite & hit_task;
  wire clr_cnt   = wr_ctrl & i_pwdata[sysd_pkg::CTRL_CLR_BIT];

  // Read data selection
  wire [31:0] stat_word = {14'h0000, o_fault, o_legacy, o_fault_vec, 1'b0, o_class};
  wire [31:0] next_rdata = hit_ctrl ? ctrl :
                           hit_task ? {16'h0000, o_task_ptr} :
                           hit_stat ? stat_word :
                           hit_flt  ? {{(32-CNT_W){1'b0}}, faults} :
                           hit_dec  ? {{(32-CNT_W){1'b0}}, decodes} :
                                      32'h0000_0000;

  // APB answer: ready one cycle into the access phase
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h0000_0000;
    end else begin
      o_pready  <= apb_acc & ~o_pready;
      o_pslverr <= apb_acc & ~o_pready & ~hit_any;
      o_prdata  <= (apb_acc & ~o_pready & ~i_pwrite) ? next_rdata : 32'h0000_0000;
    end
  end

  // Control register; clear bit does not stick
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl <= sysd_pkg::CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl <= {30'h0000_0000, 1'b0, i_pwdata[sysd_pkg::CTRL_EN_BIT]};
    end
  end

  // Task pointer; a task switch load wins over software
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_task_ptr <= sysd_pkg::TASK_RST;
    end else if (i_task_load) begin
      o_task_ptr <= i_task_sel;
    end else if (wr_task) begin
      o_task_ptr <= i_pwdata[15:0];
    end
  end

  // Statistics; a new event in the clear cycle still counts
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      decodes <= '0;
      faults  <= '0;
    end else begin
      decodes <= (clr_cnt ? '0 : decodes) + {{(CNT_W-1){1'b0}}, take};
      faults  <= (clr_cnt ? '0 : faults) + {{(CNT_W-1){1'b0}}, take & next_fault};
    end
  end

  // Checks on the decoder's own behaviour
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  property p_latency;
    take |=> o_valid ##1 (o_valid == $past(take));
  endproperty
  a_latency: assert property (p_latency) else $error("result not one cycle after request");

  property p_ldt_dpl;
    (take && is_ldt) |=> (o_class == sysd_pkg::CL_LDT) && (o_dpl == 2'b00);
  endproperty
  a_ldt_dpl: assert property (p_ldt_dpl) else $error("local table privilege not ignored");

  property p_ldt_gdt;
    (take && is_ldt && !i_from_gdt) |=> o_fault && (o_fault_vec == sysd_pkg::VEC_GEN_PROT);
  endproperty
  a_ldt_gdt: assert property (p_ldt_gdt) else $error("local table outside global not refused");

  property p_not_present;
    (take && is_gate && !present && !dif.reserved) |=> (o_fault_vec == sysd_pkg::VEC_NOT_PRESENT);
  endproperty
  a_not_present: assert property (p_not_present) else $error("absent gate not vector 11");

  property p_s_bit;
    (take && s_bit) |=> o_fault && (o_fault_vec == sysd_pkg::VEC_GEN_PROT) && (o_class == sysd_pkg::CL_INVALID);
  endproperty
  a_s_bit: assert property (p_s_bit) else $error("set S bit not refused");

  property p_copy;
    take |=> (o_copy_count == ($past(is_call && i_priv_change) ? $past(i_desc_hi[sysd_pkg::HI_WC_LSB +: 5]) : 5'h00));
  endproperty
  a_copy: assert property (p_copy) else $error("copy count wrong");

  property p_other_wc;
    (take && (is_task || is_hand)) |=> (o_word_count == 5'h00) && (o_copy_count == 5'h00);
  endproperty
  a_other_wc: assert property (p_other_wc) else $error("word count not disregarded");

  property p_invalid;
    (take && !s_bit && (i_desc_hi[sysd_pkg::HI_TYPE_LSB +: 4] == sysd_pkg::TY_RSV_D)) |=> o_invalid && o_fault;
  endproperty
  a_invalid: assert property (p_invalid) else $error("reserved type not invalid");

  property p_short;
    (take && is_seg && (i_desc_hi[sysd_pkg::HI_UPPER_LSB +: 16] == 16'h0000))
      |=> (o_base[31:24] == 8'h00) && (o_limit[19:16] == 4'h0);
  endproperty
  a_short: assert property (p_short) else $error("short layout not honoured");

  property p_busy;
    (take && is_tss) |=> (o_tss_busy == $past(i_desc_hi[sysd_pkg::HI_TYPE_LSB + 1]))
      && (o_legacy == !$past(i_desc_hi[sysd_pkg::HI_NATIVE_BIT]));
  endproperty
  a_busy: assert property (p_busy) else $error("task segment busy or layout wrong");

  property p_dest;
    (take && is_gate && present && i_dest_known && (is_task ? !i_dest_is_tss : !i_dest_is_code))
      |=> o_fault && (o_fault_vec == sysd_pkg::VEC_GEN_PROT);
  endproperty
  a_dest: assert property (p_dest) else $error("wrong destination kind not refused");

  property p_wide;
    (take && is_call) |=> (o_copy_wide == $past(i_desc_hi[sysd_pkg::HI_NATIVE_BIT]));
  endproperty
  a_wide: assert property (p_wide) else $error("copy unit wrong");

  property p_task;
    i_task_load |=> (o_task_ptr == $past(i_task_sel));
  endproperty
  a_task: assert property (p_task) else $error("task pointer not loaded");

  // A disabled decoder must not answer
  property p_refuse;
    (i_desc_valid && !ctrl[sysd_pkg::CTRL_EN_BIT]) |=> !o_valid;
  endproperty
  a_refuse: assert property (p_refuse) else $error("request taken while disabled");

  property p_apb;
    (apb_acc && !o_pready) |=> o_pready ##1 !o_pready;
  endproperty
  a_apb: assert property (p_apb) else $error("APB answer timing wrong");

endmodule

// ==== dv/sysd_seg_model.sv ====
/*
  Model of the segmentation control logic that feeds fetched descriptors
  and their qualifiers to the decoder.
  Assumes send is called right after a rising edge of i_ref_clk.
*/
`timescale 1ns/1ns
module sysd_seg_model (
  // Clock
  input  wire logic   i_ref_clk,
  // Descriptor request
  output logic        o_desc_valid,
  output logic [31:0] o_desc_lo,
  output logic [31:0] o_desc_hi,
  output logic        o_from_gdt,
  output logic        o_priv_change,
  output logic [2:0]  o_dest
);
  // Idle at time zero
  initial begin
    o_desc_valid = 1'b0;
    o_desc_lo = 32'h0;
    o_desc_hi = 32'h0;
    o_from_gdt = 1'b0;
    o_priv_change = 1'b0;
    o_dest = 3'h0;
  end

  // One request for one cycle; words inverted afterwards so stale data never passes
  task automatic send(input logic [31:0] lo, input logic [31:0] hi, input logic g, input logic p,
                      input logic [2:0] d);
    o_desc_valid <= 1'b1;
    o_desc_lo <= lo;
    o_desc_hi <= hi;
    o_from_gdt <= g;
    o_priv_change <= p;
    o_dest <= d;
    @(posedge i_ref_clk);
    o_desc_valid <= 1'b0;
    o_desc_lo <= ~lo;
    o_desc_hi <= ~hi;
  endtask
endmodule

// ==== dv/system_descriptor_decoder_tb.sv ====
/*
  Self-checking bench for the system descriptor decoder.
  Assumes the decoder answers one cycle after a taken request and APB after one wait cycle.
*/
`timescale 1ns/1ns
module system_descriptor_decoder_tb;
  logic i_ref_clk = 1'b0, i_rst = 1'b1, i_task_load = 1'b0, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
  logic [15:0] i_task_sel = 16'h0;
  logic [7:0] i_paddr = 8'h0;
  logic [31:0] i_pwdata = 32'h0, rd;
  logic dv, global_descriptor_table, pc, er;
  logic [31:0] dlo, dhi;
  logic [2:0] dst;
  logic [31:0] o_prdata, o_base, o_offset;
  logic o_pready, o_pslverr, o_valid, o_present, o_legacy, o_tss_busy, o_gran, o_copy_wide, o_invalid, o_fault;
  sysd_pkg::sysd_class_t o_class;
  logic [7:0] o_access, o_fault_vec;
  logic [1:0] o_dpl;
  logic [19:0] o_limit;
  logic [15:0] o_sel, o_task_ptr;
  logic [4:0] o_word_count, o_copy_count;
  int n_mismatch = 0, tests_run = 0;

  // Clock, 50 ns period
  always #25 i_ref_clk = ~i_ref_clk;

  sysd_seg_model seg_i (.i_ref_clk(i_ref_clk), .o_desc_valid(dv), .o_desc_lo(dlo), .o_desc_hi(dhi),
    .o_from_gdt(global_descriptor_table), .o_priv_change(pc), .o_dest(dst));

  sysd_decoder sysd_decoder_i (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_desc_valid(dv), .i_desc_lo(dlo),
    .i_desc_hi(dhi), .i_from_gdt(global_descriptor_table), .i_priv_change(pc), .i_dest_known(dst[2]), .i_dest_is_code(dst[1]),
    .i_dest_is_tss(dst[0]), .i_task_load(i_task_load), .i_task_sel(i_task_sel), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .o_valid(o_valid), .o_class(o_class), .o_access(o_access),
    .o_present(o_present), .o_dpl(o_dpl), .o_legacy(o_legacy), .o_tss_busy(o_tss_busy), .o_base(o_base),
    .o_limit(o_limit), .o_gran(o_gran), .o_sel(o_sel), .o_offset(o_offset), .o_word_count(o_word_count),
    .o_copy_count(o_copy_count), .o_copy_wide(o_copy_wide), .o_invalid(o_invalid), .o_fault(o_fault),
    .o_fault_vec(o_fault_vec), .o_task_ptr(o_task_ptr));

  // Compare and count
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Counts and verdict
  task automatic stop_test;
    $display("counts: %0d compared, %0d mismatched", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // One descriptor; result pulse seen exactly one cycle later
  task automatic dec(input logic [31:0] lo, hi, input logic g, p, input logic [2:0] d);
    @(posedge i_ref_clk);
    seg_i.send(lo, hi, g, p, d);
    #1 chk("valid", 1, o_valid);
    @(posedge i_ref_clk);
    #1 chk("valid_end", 0, o_valid);
  endtask

  // APB transfer, held until ready seen
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge i_ref_clk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_ref_clk);
    i_penable <= 1'b1;
    // Values read here are those standing before the edge
    for (n = 0; n < 20; n++) begin
      @(posedge i_ref_clk);
      if (o_pready === 1'b1) break;
    end
    if (n == 20) begin
      chk("pready", 1, 0);
      stop_test();
    end
    rd = o_prdata;
    er = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask

  // Expected class of each type code
  function automatic sysd_pkg::sysd_class_t cls_of(input logic [3:0] t);
    case (t)
      4'h1, 4'h3, 4'h9, 4'hB: cls_of = sysd_pkg::CL_TSS;
      4'h2: cls_of = sysd_pkg::CL_LDT;
      4'h4, 4'hC: cls_of = sysd_pkg::CL_CALL;
      4'h5: cls_of = sysd_pkg::CL_TASK;
      4'h6, 4'hE: cls_of = sysd_pkg::CL_INTR;
      4'h7, 4'hF: cls_of = sysd_pkg::CL_TRAP;
      default: cls_of = sysd_pkg::CL_INVALID;
    endcase
  endfunction

  // Local table descriptors, full and short layout, inside and outside the global table
  task automatic t_ldt;
    dec(32'h5678_BCDE, 32'h128A_E234, 1, 0, 0);
    chk("base", 32'h1234_5678, o_base);
    chk("limit", 20'hABCDE, o_limit);
    chk("dpl", 0, o_dpl);
    chk("class", sysd_pkg::CL_LDT, o_class);
    chk("present", 1, o_present);
    chk("gran", 1, o_gran);
    dec(32'h5678_BCDE, 32'h0000_8234, 1, 0, 0);
    chk("base16", 32'h0034_5678, o_base);
    chk("limit16", 20'h0BCDE, o_limit);
    chk("legacy", 1, o_legacy);
    dec(32'h5678_BCDE, 32'h128A_E234, 0, 0, 0);
    chk("vec", 8'h0D, o_fault_vec);
    $display("test ldt done");
  endtask

  // Every type code
  task automatic t_types;
    logic [3:0] t;
    for (int i = 0; i < 16; i++) begin
      t = i[3:0];
      dec(32'h0, {16'h1000, 4'h8, t, 8'h00}, 1, 0, 0);
      chk("class", cls_of(t), o_class);
      chk("busy", t == 4'h3 || t == 4'hB, o_tss_busy);
      chk("invalid", cls_of(t) == sysd_pkg::CL_INVALID, o_invalid);
      chk("vec", cls_of(t) == sysd_pkg::CL_INVALID ? 8'h0D : 8'h00, o_fault_vec);
      if (t inside {4'h1, 4'h3, 4'h9, 4'hB}) chk("legacy", !t[3], o_legacy);
    end
    $display("test types done");
  endtask

  // Gate fields, word count use and copy unit
  task automatic t_gates;
    for (int p = 0; p < 2; p++) begin
      dec(32'h0123_BEEF, 32'hCAFE_8C05, 1, p[0], 0);
      chk("sel", 16'h0123, o_sel);
      chk("offset", 32'hCAFE_BEEF, o_offset);
      chk("access", 8'h8C, o_access);
      chk("wc", 5, o_word_count);
      chk("copy", p ? 5 : 0, o_copy_count);
      chk("wide", 1, o_copy_wide);
    end
    dec(32'h0123_BEEF, 32'h0000_841F, 1, 1, 0);
    chk("wide16", 0, o_copy_wide);
    dec(32'h0008_5678, 32'h1234_8E1F, 1, 1, 0);
    chk("entry", 32'h1234_5678, o_offset);
    chk("isel", 16'h0008, o_sel);
    chk("iwc", 0, o_copy_count);
    dec(32'h0030_5678, 32'h1234_851F, 1, 1, 0);
    chk("twc", 0, o_word_count);
    $display("test gates done");
  endtask

  // Not present, wrong bit 4, wrong destination kind
  task automatic t_faults;
    dec(32'h0123_BEEF, 32'hCAFE_0C05, 1, 0, 0);
    chk("vecnp", 8'h0B, o_fault_vec);
    chk("present0", 0, o_present);
    chk("fault", 1, o_fault);
    dec(32'h0123_BEEF, 32'hCAFE_9C05, 1, 0, 0);
    chk("vecs", 8'h0D, o_fault_vec);
    dec(32'h0123_BEEF, 32'hCAFE_8C05, 1, 0, 3'b100);
    chk("veccode", 8'h0D, o_fault_vec);
    dec(32'h0123_BEEF, 32'hCAFE_8C05, 1, 0, 3'b110);
    chk("vecok", 8'h00, o_fault_vec);
    dec(32'h0030_0000, 32'h0000_8500, 1, 0, 3'b110);
    chk("vectask", 8'h0D, o_fault_vec);
    $display("test faults done");
  endtask

  // Task pointer load, readback, unmapped address
  task automatic t_task;
    @(posedge i_ref_clk);
    i_task_load <= 1'b1;
    i_task_sel <= 16'h0A28;
    @(posedge i_ref_clk);
    i_task_load <= 1'b0;
    #1 chk("tptr", 16'h0A28, o_task_ptr);
    apb(0, sysd_pkg::OFF_TASK, 0);
    chk("tread", 32'h0000_0A28, rd);
    apb(0, 8'h14, 0);
    chk("slverr", 1, er);
    apb(1, sysd_pkg::OFF_TASK, 32'h0000_1234);
    apb(0, sysd_pkg::OFF_TASK, 0);
    chk("twrite", 32'h0000_1234, rd);
    apb(0, sysd_pkg::OFF_DECODES, 0);
    chk("decodes", 29, rd);
    apb(0, sysd_pkg::OFF_FAULTS, 0);
    chk("faults", 9, rd);
    apb(1, sysd_pkg::OFF_CTRL, 0);
    @(posedge i_ref_clk);
    seg_i.send(32'h0, 32'h0000_8C00, 1, 0, 0);
    #1 chk("refused", 0, o_valid);
    apb(1, sysd_pkg::OFF_CTRL, 32'h0000_0003);
    apb(0, sysd_pkg::OFF_DECODES, 0);
    chk("cleared", 0, rd);
    apb(0, sysd_pkg::OFF_CTRL, 0);
    chk("ctrl", 1, rd);
    $display("test task done");
  endtask

  // Bounded run
  initial begin
    repeat (20000) @(posedge i_ref_clk);
    n_mismatch++;
    stop_test();
  end

  // Main sequence
  initial begin
    repeat (10) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    t_ldt();
    t_types();
    t_gates();
    t_faults();
    t_task();
    stop_test();
  end
endmodule
